/* File: logic/loop_routing_config_regs.vh */
// Register offsets, field positions, reset values and rate codes.
`ifndef LOOP_ROUTING_CONFIG_REGS_VH
`define LOOP_ROUTING_CONFIG_REGS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
// The printed offset 0x65 is not a multiple of four, so it is an index.
`define PRIMARY_LOOP_RATE_CONFIG_IDX   8'h65
`define PRIMARY_LOOP_RATE_CONFIG_ADDR  12'h0194
`define PRIMARY_LOOP_RATE_CONFIG_RST   8'h01
`define OUTPUT_RATE_RST                3'h1
`define ROUTING_STATUS_ADDR            12'h0198
`define APB_ADDR_W                     12

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PHASE_MEASURE_BIT              7
`define ANALOG_TWO_SRC_BIT             6
`define RATE_TO_ANALOG_TWO_HI          5
`define RATE_TO_ANALOG_TWO_LO          4
`define OUTPUT_RATE_HI                 2
`define OUTPUT_RATE_LO                 0

// ----------------------------------------------------------------------
// Rate codes for the second analog loop
// ----------------------------------------------------------------------
`define RATE_12E1                      2'h0
`define RATE_16E1                      2'h1
`define RATE_24DS1                     2'h2
`define RATE_16DS1                     2'h3

// One-hot rate select driven to the second analog loop, all zero for SEL_NONE.
`define SEL_NONE                       4'h0
`define SEL_12E1                       4'h1
`define SEL_16E1                       4'h2
`define SEL_24DS1                      4'h4
`define SEL_16DS1                      4'h8

`endif

/* File: logic/routing_decode.v */
// Combinational decode of the routing fields into loop steering controls.
`timescale 1ns/10ps
`include "loop_routing_config_regs.vh"

module routing_decode (
    // Configuration fields
    input  wire       phase_measure_enable,
    input  wire       analog_two_source_select,
    input  wire [1:0] primary_rate_to_analog_two,
    // Decoded controls
    output reg        secondary_track_en,
    output reg        phase_meas_en,
    output reg        analog_two_from_primary,
    output reg  [3:0] analog_two_rate_sel
);

    always @* begin
        secondary_track_en      = ~phase_measure_enable;
        phase_meas_en           = phase_measure_enable;
        analog_two_from_primary = analog_two_source_select;
        analog_two_rate_sel     = `SEL_NONE;
        if (analog_two_source_select) begin
            case (primary_rate_to_analog_two)
                `RATE_12E1:  analog_two_rate_sel = `SEL_12E1;
                `RATE_16E1:  analog_two_rate_sel = `SEL_16E1;
                `RATE_24DS1: analog_two_rate_sel = `SEL_24DS1;
                `RATE_16DS1: analog_two_rate_sel = `SEL_16DS1;
                default:     analog_two_rate_sel = `SEL_NONE;
            endcase
        end
    end

endmodule // routing_decode

/* File: logic/loop_routing_config_reg.v */
// Loop routing configuration register with APB access and steering outputs.
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "loop_routing_config_regs.vh"

module loop_routing_config_reg (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Loop steering
    output reg         secondary_track_en,
    output reg         phase_meas_en,
    output reg         analog_two_from_primary,
    output reg  [3:0]  analog_two_rate_sel,
    output reg  [2:0]  primary_loop_output_rate
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    reg  [7:0]  cfg_r;
    reg  [7:0]  cfg_nxt;
    wire        track_nxt;
    wire        meas_nxt;
    wire        from_pri_nxt;
    wire [3:0]  rate_sel_nxt;
    wire        hit_cfg;
    wire        hit_stat;
    wire        setup;
    reg  [31:0] rdata_nxt;

    assign setup    = psel & ~penable;
    assign hit_cfg  = (paddr == `PRIMARY_LOOP_RATE_CONFIG_ADDR);
    assign hit_stat = (paddr == `ROUTING_STATUS_ADDR);

    // ------------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------------
    // The slave answers one cycle after setup: pready rises in the first
    // access cycle, so every transfer has no wait states.  Writes land at
    // the edge that completes the access phase.
    always @* begin
        cfg_nxt = cfg_r;
        if (psel && penable && pready && pwrite && hit_cfg && pstrb[0]) begin
            cfg_nxt = pwdata[7:0];
        end
    end

    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (hit_cfg) begin
            rdata_nxt = {24'h00_0000, cfg_r};
        end else if (hit_stat) begin
            rdata_nxt = {24'h00_0000, phase_meas_en, analog_two_from_primary,
                         secondary_track_en, 1'b0, analog_two_rate_sel};
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_r   <= `PRIMARY_LOOP_RATE_CONFIG_RST;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            cfg_r   <= cfg_nxt;
            pready  <= setup;
            pslverr <= setup & ~(hit_cfg | (hit_stat & ~pwrite));
            if (setup && !pwrite) begin
                prdata <= rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Steering decode
    // ------------------------------------------------------------------
    routing_decode u_decode (
        .phase_measure_enable       (cfg_r[`PHASE_MEASURE_BIT]),
        .analog_two_source_select   (cfg_r[`ANALOG_TWO_SRC_BIT]),
        .primary_rate_to_analog_two (cfg_r[`RATE_TO_ANALOG_TWO_HI:
                                           `RATE_TO_ANALOG_TWO_LO]),
        .secondary_track_en         (track_nxt),
        .phase_meas_en              (meas_nxt),
        .analog_two_from_primary    (from_pri_nxt),
        .analog_two_rate_sel        (rate_sel_nxt)
    );

    // Outputs are registered so they follow the stored value by one cycle.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            secondary_track_en       <= 1'b1;
            phase_meas_en            <= 1'b0;
            analog_two_from_primary  <= 1'b0;
            analog_two_rate_sel      <= `SEL_NONE;
            primary_loop_output_rate <= `OUTPUT_RATE_RST;
        end else begin
            secondary_track_en       <= track_nxt;
            phase_meas_en            <= meas_nxt;
            analog_two_from_primary  <= from_pri_nxt;
            analog_two_rate_sel      <= rate_sel_nxt;
            primary_loop_output_rate <= cfg_r[`OUTPUT_RATE_HI:
                                              `OUTPUT_RATE_LO];
        end
    end

endmodule // loop_routing_config_reg

/* File: tb/routing_props.sv */
// Assertions on the steering outputs of the loop routing register.
`timescale 1ns/10ps
`include "loop_routing_config_regs.vh"
module routing_props (
    // Clock and reset
    input wire        clk,
    input wire        rst,
    // APB requests
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire        pready,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    // Loop steering
    input wire        secondary_track_en,
    input wire        phase_meas_en,
    input wire        analog_two_from_primary,
    input wire [3:0]  analog_two_rate_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A completed write to the configuration word.
    sequence wr_s;
        psel && penable && pready && pwrite && pstrb[0] &&
        paddr == `PRIMARY_LOOP_RATE_CONFIG_ADDR;
    endsequence
    property rate_p(c, s);
        wr_s ##0 pwdata[6] && pwdata[5:4] == c |->
        ##2 analog_two_rate_sel == s;
    endproperty
    AST_TRACK: assert property (wr_s ##0 !pwdata[7] |->
        ##2 secondary_track_en && !phase_meas_en) else $error("track wrong");
    AST_MEASURE: assert property (wr_s ##0 pwdata[7] |->
        ##2 phase_meas_en && !secondary_track_en) else $error("measure wrong");
    AST_SOURCE: assert property (wr_s |-> ##2
        analog_two_from_primary == $past(pwdata[6], 2)) else $error("source");
    AST_NO_RATE: assert property (wr_s ##0 !pwdata[6] |->
        ##2 analog_two_rate_sel == 4'h0) else $error("rate not idle");
    AST_RATE_12E1: assert property (rate_p(2'h0, 4'h1))
        else $error("12E1 rate wrong");
    AST_RATE_24DS1: assert property (rate_p(2'h2, 4'h4))
        else $error("24DS1 rate wrong");
    AST_RATE_16E1: assert property (rate_p(2'h1, 4'h2))
        else $error("16E1 rate wrong");
    AST_RATE_16DS1: assert property (rate_p(2'h3, 4'h8))
        else $error("16DS1 rate wrong");
endmodule // routing_props
bind loop_routing_config_reg routing_props u_props (.clk, .rst, .psel,
    .penable, .pwrite, .pready, .paddr, .pwdata, .pstrb,
    .analog_two_rate_sel, .secondary_track_en, .phase_meas_en,
    .analog_two_from_primary);

/* File: tb/tb_top.sv */
// Self-checking bench for the loop routing configuration register.
`timescale 1ns/10ps
`include "loop_routing_config_regs.vh"
module tb_top;
    reg         clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, rd;
    reg  [3:0]  pstrb = 0;
    wire [31:0] prdata;
    wire        pready, pslverr, secondary_track_en, phase_meas_en;
    wire        analog_two_from_primary;
    wire [3:0]  analog_two_rate_sel;
    wire [2:0]  primary_loop_output_rate;
    integer     err_count = 0, checks_done = 0, cyc = 0, i;
    always #50 clk = ~clk;
    loop_routing_config_reg i_dut (.clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .secondary_track_en, .phase_meas_en, .analog_two_from_primary,
        .analog_two_rate_sel, .primary_loop_output_rate);
    task chk(input string nm, input [31:0] got, exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk_out(input [7:0] v);
        @(posedge clk);
        #1;
        chk("steering", {secondary_track_en, phase_meas_en,
            analog_two_from_primary, analog_two_rate_sel,
            primary_loop_output_rate}, {~v[7], v[7], v[6],
            v[6] ? 4'h1 << v[5:4] : 4'h0, v[2:0]});
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            final_report;
        end
    end
    // ----
    // Reset value, every routing code, then refused accesses.
    // ----
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(0, `PRIMARY_LOOP_RATE_CONFIG_ADDR, 0, 4'h0);
        chk("cfg reset", rd, {24'h0, `PRIMARY_LOOP_RATE_CONFIG_RST});
        chk_out(`PRIMARY_LOOP_RATE_CONFIG_RST);
        $display("test reset done");
        for (i = 0; i < 16; i = i + 1) begin
            apb(1, `PRIMARY_LOOP_RATE_CONFIG_ADDR, {24'h0, i[3:0], 4'h5}, 4'h1);
            chk_out({i[3:0], 4'h5});
            apb(0, `PRIMARY_LOOP_RATE_CONFIG_ADDR, 0, 4'h0);
            chk("cfg read", rd, {24'h0, i[3:0], 4'h5});
            chk("cfg read err", er, 1'b0);
        end
        $display("test routing done");
        apb(1, `PRIMARY_LOOP_RATE_CONFIG_ADDR, 32'h0000_00c2, 4'he);
        chk_out(8'hf5);
        apb(0, `ROUTING_STATUS_ADDR, 0, 4'h0);
        chk("status read", rd, 32'h0000_00c8);
        chk("status err", er, 1'b0);
        apb(0, 12'h0ff0, 0, 4'h0);
        chk("unmapped err", er, 1'b1);
        chk("unmapped data", rd, 32'h0000_0000);
        apb(1, `ROUTING_STATUS_ADDR, 0, 4'hf);
        chk("status write", er, 1'b1);
        $display("test refusal done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(0, `PRIMARY_LOOP_RATE_CONFIG_ADDR, 0, 4'h0);
        chk("cfg re-reset", rd, {24'h0, `PRIMARY_LOOP_RATE_CONFIG_RST});
        chk_out(`PRIMARY_LOOP_RATE_CONFIG_RST);
        $display("test mid-run reset done");
        final_report;
    end
endmodule // tb_top
